// ---- dv/cell_monitor_serial_command_unit_tb_top.sv ----
// self-checking bench of the cell monitor serial command unit
`timescale 1ns/1ps
`default_nettype none
`include "cell_mon_defines.svh"
module cell_monitor_serial_command_unit_tb_top;
  localparam int HALF_CYC = 30;
  logic clk, rst, cs_n, sck, sdi, sdo, sdo_oe_n, wdt_n, trip, lvl, irq, busy, trip_st, wdt_st, settling, mod_tick;
  logic [3:0] dev_addr, cell_sel;
  logic [11:0] adc_code, die_t, dis, mask, uvf, ovf;
  logic [1:0][11:0] ext_t;
  logic [7:0] uv_set, ov_set;
  logic [11:0][11:0] codes;
  logic [7:0] rb [0:18];
  int error_cnt, compares, n, settle_n, window_n, tick_n;
  logic last;

  cell_monitor_serial_command_unit #(.SETTLE_CYC(40), .WINDOW_CYC(40), .HALF_CYC(HALF_CYC))
    i_cell_monitor_serial_command_unit (
    .clk(clk), .rst(rst), .chip_select_in_n(cs_n), .serial_clk(sck), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_oe_n(sdo_oe_n), .device_address(dev_addr),
    .watchdog_out_n(wdt_n), .overheat_trip(trip), .adc_code(adc_code), .ext_temp_result(ext_t),
    .die_temp_result(die_t), .adc_cell_sel(cell_sel), .adc_settling(settling), .adc_mod_tick(mod_tick),
    .cell_discharge_on(dis), .cell_irq_mask(mask), .undervolt_threshold_setting(uv_set),
    .overvolt_threshold_setting(ov_set), .level_poll_select(lvl), .cell_result_code(codes),
    .cell_undervolt_flag(uvf), .cell_overvolt_flag(ovf), .irq_present(irq), .conversion_busy(busy),
    .overheat_trip_status(trip_st), .watchdog_status_bit(wdt_st));

  serial_host_model i_serial_host_model (
    .clk(clk), .chip_select_in_n(cs_n), .serial_clk(sck), .serial_data_in(sdi), .serial_data_out(sdo));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // converter front end: each cell reads 500 + 300 * index
  always @(negedge clk) begin
    adc_code <= 12'(500 + 300 * cell_sel);
  end

  // converter phase counts while a conversion runs
  always @(negedge clk) begin
    if (busy === 1'b1 && settling === 1'b1) settle_n++;
    if (busy === 1'b1 && settling === 1'b0) window_n++;
    if (mod_tick === 1'b1) tick_n++;
  end

  // packet check byte, msb first
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ `PEC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one byte followed by its own check byte
  task automatic put(input logic [7:0] b);
    logic [7:0] r;
    i_serial_host_model.xfer(b, r);
    i_serial_host_model.xfer(crc(`PEC_SEED, b), r);
  endtask

  // n reply bytes and the check byte over them
  task automatic get(input int cnt);
    logic [7:0] p;
    p = `PEC_SEED;
    for (int i = 0; i <= cnt; i++) begin
      i_serial_host_model.xfer(8'h00, rb[i]);
      if (i < cnt) p = crc(p, rb[i]);
    end
    check("reply pec", p, rb[cnt]);
  endtask

  // broadcast configuration write, discharge held until deselect
  task automatic cfg(input logic [7:0] b0, input logic [11:0] d, input logic [11:0] m, input logic [7:0] u,
                     input logic [7:0] o);
    logic [7:0] r, p;
    logic [11:0] old;
    logic [7:0] by [6];
    by = '{b0, d[7:0], {m[3:0], d[11:8]}, m[11:4], u, o};
    old = dis;
    p = `PEC_SEED;
    i_serial_host_model.frame_open();
    put(`CMD_WRITE_CONFIG);
    foreach (by[i]) begin
      i_serial_host_model.xfer(by[i], r);
      p = crc(p, by[i]);
    end
    i_serial_host_model.xfer(p, r);
    repeat (8) @(negedge clk);
    check("discharge before latch", old, dis);
    i_serial_host_model.frame_close();
    check("config", {d, m, u, o, b0[4]}, {dis, mask, uv_set, ov_set, lvl});
  endtask

  // broadcast start, busy results, poll low until done
  task automatic conv();
    settle_n = 0;
    window_n = 0;
    tick_n = 0;
    i_serial_host_model.frame_open();
    put(`CMD_START_CELL_CONVERSION);
    repeat (4) @(negedge clk);
    check("busy", 1, busy);
    check("busy code", `CODE_BUSY, codes[5]);
    check("poll while busy", 2'b00, {sdo_oe_n, sdo});
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
    check("busy end", 0, busy);
    check("settle cycles", 12 * 40, settle_n);
    check("window cycles", 12 * 40, window_n);
    check("mod ticks", 12 * (40 * `MOD_KHZ / (`CLK_MHZ * 1000)), tick_n);
  endtask

  // codes and flags against the thresholds worked out from the settings
  task automatic results(input logic [11:0] m, input logic [7:0] u, input logic [7:0] o);
    logic [11:0] eu, eo;
    for (int i = 0; i < 12; i++) begin
      eu[i] = !m[i] && (500 + 300 * i < (int'(u) - 31) * 16 + 512);
      eo[i] = !m[i] && (500 + 300 * i > (int'(o) - 32) * 16 + 512);
      check("cell code", 500 + 300 * i, codes[i]);
    end
    check("uv flags", eu, uvf);
    check("ov flags", eo, ovf);
    check("irq", |{eu, eo}, irq);
  endtask

  // addressed interrupt poll
  task automatic poll(input logic [3:0] a, input logic [1:0] e);
    i_serial_host_model.frame_open();
    put({`ADDR_PREFIX, a});
    put(`CMD_POLL_IRQ);
    repeat (8) @(negedge clk);
    check("irq poll", e, {sdo_oe_n, sdo});
    i_serial_host_model.frame_close();
    check("released", 1, sdo_oe_n);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog on a hung run
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    wdt_n = 1'b1;
    trip = 1'b0;
    dev_addr = 4'h3;
    adc_code = 12'h000;
    ext_t = {12'h3c9, 12'h7a5};
    die_t = 12'h9d2;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("reset state", {1'b1, 29'h0}, {sdo_oe_n, dis, uv_set, ov_set, lvl});
    wdt_n = 1'b0;
    repeat (6) @(negedge clk);
    check("watchdog low", 0, wdt_st);
    wdt_n = 1'b1;
    repeat (6) @(negedge clk);
    check("watchdog high", 1, wdt_st);
    cfg(8'h00, 12'ha5c, 12'h800, 8'h20, 8'hd0);
    conv();
    last = sdo;
    for (int i = 0; i < 2 * HALF_CYC && sdo === last; i++) @(negedge clk);
    last = sdo;
    n = 0;
    for (int i = 0; i < 4 * HALF_CYC; i++) begin
      @(negedge clk);
      if (sdo !== last) n++;
      last = sdo;
    end
    check("toggle count", 4, n);
    i_serial_host_model.frame_close();
    check("released", 1, sdo_oe_n);
    results(12'h800, 8'h20, 8'hd0);
    i_serial_host_model.frame_open();
    put({`ADDR_PREFIX, 4'h3});
    put(`CMD_READ_CELLS);
    get(18);
    i_serial_host_model.frame_close();
    // byte 0 low of even cell, byte 1 odd low nibble and even high nibble, byte 2 odd high
    for (int p = 0; p < 6; p++) begin
      check("cell bytes", {12'(500 + 600 * p), 12'(800 + 600 * p)}, {rb[3 * p + 1][3:0], rb[3 * p], rb[3 * p + 2], rb[3 * p + 1][7:4]});
    end
    poll(4'h3, 2'b00);
    poll(4'h4, 2'b10);
    trip = 1'b1;
    repeat (10) @(negedge clk);
    trip = 1'b0;
    repeat (6) @(negedge clk);
    check("overheat set", 1, trip_st);
    i_serial_host_model.frame_open();
    put({`ADDR_PREFIX, 4'h3});
    put(`CMD_READ_TEMPS);
    get(5);
    i_serial_host_model.frame_close();
    check("ext temps", {ext_t[0][7:0], ext_t[1][3:0], ext_t[0][11:8], ext_t[1][11:4]}, {rb[0], rb[1], rb[2]});
    check("die temp", {die_t[7:0], 4'h1, die_t[11:8]}, {rb[3], rb[4]});
    check("overheat cleared", 0, trip_st);
    cfg(8'h10, 12'h000, 12'h801, 8'h20, 8'hd0);
    check("masked flag", 0, uvf[0]);
    conv();
    repeat (6) @(negedge clk);
    check("level poll", 2'b01, {sdo_oe_n, sdo});
    i_serial_host_model.frame_close();
    results(12'h801, 8'h20, 8'hd0);
    summarize();
  end
endmodule
`default_nettype wire

// ---- dv/serial_host_model.sv ----
// host processor model that drives the monitor serial port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic chip_select_in_n,
  output logic serial_clk,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  // half period of the 48 ns link clock, in system clocks
  localparam int HALF = 6;
  // deselected, link clock still and low between frames
  initial begin
    chip_select_in_n = 1'b1;
    serial_clk = 1'b0;
    serial_data_in = 1'b1;
  end
  // select the device, then let the select settle
  task automatic frame_open();
    @(negedge clk);
    chip_select_in_n = 1'b0;
    repeat (HALF) @(negedge clk);
  endtask
  // one byte out msb first, reply taken at each rising link edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_data_in = tx[i];
      repeat (HALF) @(negedge clk);
      serial_clk = 1'b1;
      rx[i] = serial_data_out;
      repeat (HALF) @(negedge clk);
      serial_clk = 1'b0;
    end
  endtask
  // deselect ends the frame or the polling; data line shows the inverse
  task automatic frame_close();
    repeat (HALF) @(negedge clk);
    chip_select_in_n = 1'b1;
    serial_data_in = ~serial_data_in;
    repeat (2 * HALF) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- pkg/cell_mon_defines.svh ----
// constants for the cell monitor serial command unit
`ifndef CELL_MON_DEFINES_SVH
`define CELL_MON_DEFINES_SVH
`define CMD_WRITE_CONFIG 8'h01
`define CMD_READ_CELLS 8'h04
`define CMD_READ_TEMPS 8'h0e
`define CMD_START_CELL_CONVERSION 8'h10
`define CMD_POLL_IRQ 8'h50
`define ADDR_PREFIX 4'h8
`define PEC_SEED 8'h41
`define PEC_POLY 8'h07
`define CFG_LAST 5'h05
`define CELL_BYTES 5'h12
`define TEMP_BYTES 5'h05
`define CELL_LAST 4'hb
`define CODE_BUSY 12'hfff
`define CODE_OFFSET 512
`define UV_OFFSET 31
`define OV_OFFSET 32
`define THR_STEP 16
`define CFG_B_CTL 0
`define CFG_B_DIS 1
`define CFG_B_MIX 2
`define CFG_B_MASK 3
`define CFG_B_UV 4
`define CFG_B_OV 5
`define CFG_LVL_BIT 4
`define CLK_MHZ 250
`define SETTLE_US 500
`define WINDOW_US 500
`define MOD_KHZ 512
`define TOGGLE_HZ 1000
`endif

// ---- pkg/cell_mon_pkg.sv ----
// types for the cell monitor serial command unit
`default_nettype none
package cell_mon_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ADDR_PEC = 4'h1, ST_CMD = 4'h2, ST_CMD_PEC = 4'h3, ST_WR_DATA = 4'h4,
    ST_WR_PEC = 4'h5, ST_WR_DONE = 4'h6, ST_SEND = 4'h7, ST_POLL = 4'h8, ST_IGNORE = 4'h9
  } cmd_state_t;
  typedef struct packed {
    logic [2:0] cs, ck;
    logic [1:0] di;
    logic [2:0] bits;
    logic [7:0] rsh, tsh, rx_byte;
    logic rx_valid, tx_take, cs_rise;
  } port_state_t;
  typedef struct packed {
    cmd_state_t st;
    logic bcast, match;
    logic [7:0] crc, cmd;
    logic [4:0] cnt;
    logic [5:0][7:0] cfg_rx;
    logic [11:0] dis, mask, uvf, ovf;
    logic [7:0] uv, ov;
    logic lvl;
    logic [11:0][11:0] cells;
    logic conv, settle;
    logic [3:0] cidx;
    logic [23:0] tmr, ptmr;
    logic [9:0] mtmr;
    logic mod_tick, ptog, pollirq, trip;
    logic [1:0] wdt_s, trip_s;
    logic [1:0][3:0] addr_s;
    logic sdo, sdo_oe_n;
  } core_state_t;
endpackage
`default_nettype wire

// ---- pkg/serial_link_if.sv ----
// byte level link between serial pin port and command core
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic cs_rise;
  logic tx_take;
  logic tx_bit;
  logic [7:0] tx_byte;
  modport port (output rx_valid, rx_byte, cs_rise, tx_take, tx_bit, input tx_byte);
  modport core (input rx_valid, rx_byte, cs_rise, tx_take, tx_bit, output tx_byte);
endinterface
`default_nettype wire

// ---- rtl/cell_monitor_serial_command_unit.sv ----
// serial command unit of a stackable multicell monitor
`timescale 1ns/1ps
`default_nettype none
`include "cell_mon_defines.svh"
module cell_monitor_serial_command_unit #(
  parameter int SETTLE_CYC = `SETTLE_US * `CLK_MHZ,
  parameter int WINDOW_CYC = `WINDOW_US * `CLK_MHZ,
  parameter int HALF_CYC = `CLK_MHZ * 1000000 / (2 * `TOGGLE_HZ)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire logic chip_select_in_n,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe_n,
  // device pins
  input wire logic [3:0] device_address,
  input wire logic watchdog_out_n,
  input wire logic overheat_trip,
  // converter front end
  input wire logic [11:0] adc_code,
  input wire logic [1:0][11:0] ext_temp_result,
  input wire logic [11:0] die_temp_result,
  output logic [3:0] adc_cell_sel,
  output logic adc_settling,
  output logic adc_mod_tick,
  // configuration and status
  output logic [11:0] cell_discharge_on,
  output logic [11:0] cell_irq_mask,
  output logic [7:0] undervolt_threshold_setting,
  output logic [7:0] overvolt_threshold_setting,
  output logic level_poll_select,
  output logic [11:0][11:0] cell_result_code,
  output logic [11:0] cell_undervolt_flag,
  output logic [11:0] cell_overvolt_flag,
  output logic irq_present,
  output logic conversion_busy,
  output logic overheat_trip_status,
  output logic watchdog_status_bit
);
  import cell_mon_pkg::*;
  localparam int MOD_CYC = `CLK_MHZ * 1000 / `MOD_KHZ;

  serial_link_if link ();
  core_state_t s, n;
  logic [7:0] b, crcn, tx_data;
  logic [12:0] uv_thr, ov_thr;
  logic uv_hit, ov_hit, latch_evt, start_evt, cap_evt, clr_trip, dis_evt;
  logic [2:0] pair;
  logic [1:0] phase;
  logic [11:0] code_a, code_b;
  logic [4:0] len;
  logic temps;

  // serial pin port
  serial_byte_port port_u (
    .clk(clk),
    .rst(rst),
    .chip_select_in_n(chip_select_in_n),
    .serial_clk(serial_clk),
    .serial_data_in(serial_data_in),
    .link(link.port)
  );

  // packet check byte, one byte folded in
  function automatic logic [7:0] pec_next(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? `PEC_POLY : 8'h00);
    end
    return r;
  endfunction

  // thresholds in code units, all unsigned
  assign uv_thr = 13'(s.uv) * 13'(`THR_STEP) + 13'(`CODE_OFFSET) - 13'(`UV_OFFSET * `THR_STEP);
  assign ov_thr = 13'(s.ov) * 13'(`THR_STEP) + 13'(`CODE_OFFSET) - 13'(`OV_OFFSET * `THR_STEP);
  assign uv_hit = {1'b0, adc_code} < uv_thr;
  assign ov_hit = {1'b0, adc_code} > ov_thr;
  assign b = link.rx_byte;
  assign crcn = pec_next(s.crc, b);
  assign dis_evt = latch_evt | s.trip_s[1];

  // read group byte selection
  always_comb begin
    temps = s.cmd == `CMD_READ_TEMPS;
    len = temps ? `TEMP_BYTES : `CELL_BYTES;
    pair = 3'(s.cnt / 5'h3);
    phase = 2'(s.cnt % 5'h3);
    code_a = 12'h000;
    code_b = 12'h000;
    if (temps) begin
      code_a = ext_temp_result[0];
      code_b = ext_temp_result[1];
    end else if (s.cnt < `CELL_BYTES) begin
      code_a = s.cells[{pair, 1'b0}];
      code_b = s.cells[{pair, 1'b1}];
    end
    case (phase)
      2'h0: tx_data = code_a[7:0];
      2'h1: tx_data = {code_b[3:0], code_a[11:8]};
      default: tx_data = code_b[11:4];
    endcase
    if (temps && s.cnt == 5'h3) begin
      tx_data = die_temp_result[7:0];
    end else if (temps && s.cnt == 5'h4) begin
      tx_data = {3'h0, s.trip, die_temp_result[11:8]};
    end
    if (s.cnt < len) begin
      link.tx_byte = tx_data;
    end else if (s.cnt == len) begin
      link.tx_byte = s.crc;
    end else begin
      link.tx_byte = 8'h00;
    end
  end

  // command sequencing, converter and poll logic
  always_comb begin
    n = s;
    n.wdt_s = {s.wdt_s[0], watchdog_out_n};
    n.trip_s = {s.trip_s[0], overheat_trip};
    n.addr_s = {s.addr_s[0], device_address};
    n.mod_tick = 1'b0;
    latch_evt = 1'b0;
    start_evt = 1'b0;
    cap_evt = 1'b0;
    clr_trip = 1'b0;
    if (link.cs_rise) begin
      if (s.st == ST_WR_DONE) begin
        latch_evt = 1'b1;
        n.lvl = s.cfg_rx[`CFG_B_CTL][`CFG_LVL_BIT];
        n.dis = {s.cfg_rx[`CFG_B_MIX][3:0], s.cfg_rx[`CFG_B_DIS]};
        n.mask = {s.cfg_rx[`CFG_B_MASK], s.cfg_rx[`CFG_B_MIX][7:4]};
        n.uv = s.cfg_rx[`CFG_B_UV];
        n.ov = s.cfg_rx[`CFG_B_OV];
      end
      n.st = ST_IDLE;
      n.crc = `PEC_SEED;
    end else if (link.rx_valid) begin
      case (s.st)
        ST_IDLE: begin
          n.crc = crcn;
          if (b[7:4] == `ADDR_PREFIX) begin
            n.match = b[3:0] == s.addr_s[1];
            n.st = ST_ADDR_PEC;
          end else begin
            n.cmd = b;
            n.bcast = 1'b1;
            n.st = ST_CMD_PEC;
          end
        end
        ST_ADDR_PEC: begin
          n.st = (b == s.crc) ? ST_CMD : ST_IGNORE;
          n.crc = `PEC_SEED;
        end
        ST_CMD: begin
          n.cmd = b;
          n.bcast = 1'b0;
          n.crc = crcn;
          n.st = ST_CMD_PEC;
        end
        ST_CMD_PEC: begin
          n.st = ST_IGNORE;
          n.cnt = 5'h0;
          n.crc = `PEC_SEED;
          if (b == s.crc && (s.bcast || s.match)) begin
            case (s.cmd)
              `CMD_WRITE_CONFIG: n.st = ST_WR_DATA;
              `CMD_START_CELL_CONVERSION: begin
                start_evt = ~s.trip_s[1];
                n.pollirq = 1'b0;
                n.st = ST_POLL;
              end
              `CMD_READ_CELLS: n.st = s.bcast ? ST_IGNORE : ST_SEND;
              `CMD_READ_TEMPS: n.st = s.bcast ? ST_IGNORE : ST_SEND;
              `CMD_POLL_IRQ: begin
                n.pollirq = 1'b1;
                n.st = s.bcast ? ST_IGNORE : ST_POLL;
              end
              default: n.st = ST_IGNORE;
            endcase
          end
        end
        ST_WR_DATA: begin
          n.cfg_rx[s.cnt[2:0]] = b;
          n.crc = crcn;
          n.cnt = s.cnt + 5'h1;
          if (s.cnt == `CFG_LAST) begin
            n.st = ST_WR_PEC;
          end
        end
        ST_WR_PEC: n.st = (b == s.crc) ? ST_WR_DONE : ST_IGNORE;
        ST_WR_DONE: n.st = ST_IGNORE;
        default: n.st = s.st;
      endcase
    end
    // answer bytes, check byte folded over the data
    if (link.tx_take && s.st == ST_SEND && s.cnt <= len) begin
      n.cnt = s.cnt + 5'h1;
      // overheat status is cleared once its byte has been taken for sending
      clr_trip = temps && s.cnt == 5'h4;
      if (s.cnt < len) begin
        n.crc = pec_next(s.crc, link.tx_byte);
      end
    end
    // converter sequencing: settle then window, per cell
    if (start_evt) begin
      n.conv = 1'b1;
      n.settle = 1'b1;
      n.cidx = 4'h0;
      n.tmr = 24'h0;
      n.mtmr = 10'h0;
      for (int i = 0; i < 12; i++) begin
        n.cells[i] = `CODE_BUSY;
      end
    end else if (s.conv) begin
      n.tmr = s.tmr + 24'h1;
      if (!s.settle) begin
        n.mtmr = (s.mtmr == 10'(MOD_CYC - 1)) ? 10'h0 : s.mtmr + 10'h1;
        n.mod_tick = s.mtmr == 10'(MOD_CYC - 1);
      end
      if (s.settle && s.tmr == 24'(SETTLE_CYC - 1)) begin
        n.settle = 1'b0;
        n.tmr = 24'h0;
        n.mtmr = 10'h0;
      end else if (!s.settle && s.tmr == 24'(WINDOW_CYC - 1)) begin
        cap_evt = 1'b1;
        n.cells[s.cidx] = adc_code;
        n.uvf[s.cidx] = uv_hit;
        n.ovf[s.cidx] = ov_hit;
        n.tmr = 24'h0;
        n.settle = 1'b1;
        n.cidx = s.cidx + 4'h1;
        n.conv = s.cidx != `CELL_LAST;
      end
    end
    // overheat: sticky status, config back to defaults
    if (s.trip_s[1]) begin
      n.dis = 12'h000;
      n.mask = 12'h000;
      n.uv = 8'h00;
      n.ov = 8'h00;
      n.lvl = 1'b0;
      n.conv = 1'b0;
    end
    n.trip = s.trip_s[1] | (s.trip & ~clr_trip);
    n.uvf = n.uvf & ~n.mask;
    n.ovf = n.ovf & ~n.mask;
    // poll toggle timer runs once conversions are done
    if (n.st == ST_POLL && !s.conv) begin
      n.ptmr = (s.ptmr == 24'(HALF_CYC - 1)) ? 24'h0 : s.ptmr + 24'h1;
      n.ptog = (s.ptmr == 24'(HALF_CYC - 1)) ? ~s.ptog : s.ptog;
    end else begin
      n.ptmr = 24'h0;
      n.ptog = 1'b0;
    end
    // data out drive
    n.sdo_oe_n = 1'b1;
    n.sdo = 1'b0;
    if (n.st == ST_SEND) begin
      n.sdo_oe_n = 1'b0;
      n.sdo = link.tx_bit;
    end else if (n.st == ST_POLL) begin
      n.sdo_oe_n = 1'b0;
      if (n.pollirq) begin
        n.sdo = ~irq_present;
      end else if (s.conv || start_evt) begin
        n.sdo = 1'b0;
      end else begin
        n.sdo = s.lvl ? 1'b1 : s.ptog;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.crc <= `PEC_SEED;
      s.sdo_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs
  assign serial_data_out = s.sdo;
  assign serial_data_out_oe_n = s.sdo_oe_n;
  assign adc_cell_sel = s.cidx;
  assign adc_settling = s.conv & s.settle;
  assign adc_mod_tick = s.mod_tick;
  assign cell_discharge_on = s.dis;
  assign cell_irq_mask = s.mask;
  assign undervolt_threshold_setting = s.uv;
  assign overvolt_threshold_setting = s.ov;
  assign level_poll_select = s.lvl;
  assign cell_result_code = s.cells;
  assign cell_undervolt_flag = s.uvf;
  assign cell_overvolt_flag = s.ovf;
  assign irq_present = |{s.uvf, s.ovf};
  assign conversion_busy = s.conv;
  assign overheat_trip_status = s.trip;
  assign watchdog_status_bit = s.wdt_s[1];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  dis_latch_a: assert property ($changed(s.dis) |-> $past(dis_evt))
    else $error("discharge changed outside a latch");
  wdt_level_a: assert property (!$past(rst) && !$past(rst, 2) |-> watchdog_status_bit == $past(watchdog_out_n, 2))
    else $error("watchdog status not following pin");
  busy_code_a: assert property (start_evt |=> cell_result_code[5] == `CODE_BUSY && conversion_busy)
    else $error("result not busy after start");
  uv_flag_a: assert property (cap_evt && s.cidx == 4'h0 && !n.mask[0] |=> s.uvf[0] == $past(uv_hit))
    else $error("undervolt flag wrong");
  ov_flag_a: assert property (cap_evt && s.cidx == 4'h0 && !n.mask[0] |=> s.ovf[0] == $past(ov_hit))
    else $error("overvolt flag wrong");
  mask_clear_a: assert property (s.mask[3] |-> !s.uvf[3] && !s.ovf[3])
    else $error("masked cell flag set");
  poll_busy_a: assert property (!s.sdo_oe_n && s.st == ST_POLL && !s.pollirq && s.conv |=> !s.sdo)
    else $error("poll line not low while busy");
  poll_irq_a: assert property (s.st == ST_POLL && s.pollirq && !link.cs_rise
    |=> !serial_data_out_oe_n && serial_data_out == !$past(irq_present))
    else $error("irq poll level wrong");
  cs_release_a: assert property (link.cs_rise |=> serial_data_out_oe_n)
    else $error("data out still driven after frame");
  trip_set_a: assert property (s.trip_s[1] |=> overheat_trip_status && cell_discharge_on == 12'h000)
    else $error("overheat not handled");

  conv_done_c: cover property (cap_evt && s.cidx == `CELL_LAST);
  cfg_latch_c: cover property (latch_evt);
  poll_tog_c: cover property (s.st == ST_POLL && $changed(s.ptog));
  read_pec_c: cover property (link.tx_take && s.st == ST_SEND && s.cnt == `CELL_BYTES);
endmodule
`default_nettype wire

// ---- rtl/serial_byte_port.sv ----
// serial pin sampler, byte shifter in and out
`timescale 1ns/1ps
`default_nettype none
module serial_byte_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire logic chip_select_in_n,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  // byte side
  serial_link_if.port link
);
  import cell_mon_pkg::*;
  port_state_t s, n;
  logic cs_fall, cs_up, ck_rise, ck_fall;

  // edge finding on synchronised pins
  assign cs_fall = s.cs[2] & ~s.cs[1];
  assign cs_up = ~s.cs[2] & s.cs[1];
  assign ck_rise = ~s.ck[2] & s.ck[1] & ~s.cs[1];
  assign ck_fall = s.ck[2] & ~s.ck[1] & ~s.cs[1];

  // shift in on rising clock, out on falling clock
  always_comb begin
    n = s;
    n.cs = {s.cs[1:0], chip_select_in_n};
    n.ck = {s.ck[1:0], serial_clk};
    n.di = {s.di[0], serial_data_in};
    n.rx_valid = 1'b0;
    n.tx_take = 1'b0;
    n.cs_rise = 1'b0;
    if (cs_fall) begin
      n.bits = 3'h0;
      n.tsh = link.tx_byte;
      n.tx_take = 1'b1;
    end else if (cs_up) begin
      n.cs_rise = 1'b1;
    end else begin
      if (ck_rise) begin
        n.rsh = {s.rsh[6:0], s.di[1]};
        n.bits = s.bits + 3'h1;
        if (s.bits == 3'h7) begin
          n.rx_byte = {s.rsh[6:0], s.di[1]};
          n.rx_valid = 1'b1;
        end
      end
      if (ck_fall) begin
        if (s.bits == 3'h0) begin
          n.tsh = link.tx_byte;
          n.tx_take = 1'b1;
        end else begin
          n.tsh = {s.tsh[6:0], 1'b0};
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.cs <= 3'h7;
    end else begin
      s <= n;
    end
  end

  // byte side outputs
  assign link.rx_valid = s.rx_valid;
  assign link.rx_byte = s.rx_byte;
  assign link.cs_rise = s.cs_rise;
  assign link.tx_take = s.tx_take;
  assign link.tx_bit = s.tsh[7];
endmodule
`default_nettype wire
